//--- src/cst_map.svh
// register offsets, field positions, codes and reset values of the schedule timers
`ifndef CST_MAP_SVH
`define CST_MAP_SVH
`define CST_CHAN_SHIFT 4
`define CST_REG_ON 2'h0
`define CST_REG_OFF 2'h1
`define CST_REG_MODE 2'h2
`define CST_REG_STATE 2'h3
`define CST_REG_SUMMARY 8'h40
`define CST_HOUR_LSB 16
`define CST_MIN_LSB 8
`define CST_SEC_LSB 0
`define CST_MODE_DISABLED 4'h0
`define CST_MODE_DAILY 4'h1
`define CST_MODE_MONDAY 4'h2
`define CST_MODE_SUNDAY 4'h8
`define CST_MODE_WORKDAYS_ONLY 4'h9
`define CST_MODE_MONDAY_TO_SATURDAY 4'ha
`define CST_MODE_WEEKEND_ONLY 4'hb
`define CST_DAY_FRIDAY 3'h4
`define CST_DAY_SATURDAY 3'h5
`define CST_DAY_SUNDAY 3'h6
`define CST_STATE_UNUSED 2'h0
`define CST_STATE_INACTIVE 2'h2
`define CST_STATE_ACTIVE 2'h3
`define CST_MODE_RST 4'h0
`define CST_TIME_RST 17'h00000
`define CST_SAVED_MARK 1'h1
`endif

//--- src/cst_nv_store.sv
// small retained store for channel states, registered read, no reset on the array
`timescale 1ns/1ps
module cst_nv_store #(
	parameter int WIDTH = 2,
	parameter int DEPTH = 4,
	parameter int AW = 2
) (
	input wire logic clk_i,
	input wire logic we_i,
	input wire logic [AW-1:0] waddr_i,
	input wire logic [WIDTH-1:0] wdata_i,
	input wire logic [AW-1:0] raddr_i,
	output logic [WIDTH-1:0] rdata_o
);
	// contents must outlive the block reset, so the array is never cleared
	logic [WIDTH-1:0] mem [DEPTH];

	always_ff @(posedge clk_i)
	begin
		if (we_i)
		begin
			mem[waddr_i] <= wdata_i;
		end
		rdata_o <= mem[raddr_i];
	end
endmodule

//--- src/cst_pkg.sv
// types shared by the calendar schedule timer files
package cst_pkg;
	typedef struct packed {
		logic [4:0] hour;
		logic [5:0] minute;
		logic [5:0] second;
	} cst_time_s;
	typedef struct packed {
		cst_time_s tod;
		logic [2:0] wday;
	} cst_cal_s;
	typedef struct packed {
		logic mark;
		logic active;
	} cst_saved_s;
	typedef logic [3:0] cst_mode_t;
endpackage

//--- src/cst_sched_timers.sv
// four calendar schedule timer channels with a classic wishbone register slave
// Summary of operation
// (R1) four channels, each with own on time, off time, mode and state
// (R2) on and off times are written as hour, minute and second fields
// (R3) mode field offers twelve settings, code zero being disabled
// (R4) disabled channel does not run and its output stays zero
// (R5) daily mode switches on and off every day
// (R6) seven single-day modes switch only on the chosen weekday
// (R7) workdays_only mode switches Monday to Friday, idle at weekend
// (R8) monday_to_saturday mode switches every day except Sunday
// (R9) weekend_only mode switches Saturday and Sunday only
// (R10) channels in use may be forced on or off; disabled ones ignore forcing
// (R11) forcing is just a write of the state register, no extra flag
// (R12) forced value holds until next write or next opposite scheduled edge
// (R13) states saved to retained store on power loss, restored at start-up
// (R14) each channel output goes to the logic and routing matrix
// (R15) readable state: not in use, inactive, active
// (R16) on an enabled day output goes high at on time, low at off time
`timescale 1ns/1ps
`include "cst_map.svh"
module cst_sched_timers #(
	parameter int CHANNELS = 4, // R1
	parameter int AW = 8
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [AW-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire cst_pkg::cst_cal_s cal_i,
	input wire logic power_fail_i,
	output logic [CHANNELS-1:0] sched_out_o,
	output logic restore_busy_o
);
	typedef enum {
		SEQ_FETCH,
		SEQ_LOAD,
		SEQ_RUN,
		SEQ_SAVE
	} cst_seq_e;

	function automatic logic [31:0] merge_bytes(input logic [31:0] old_w,
		input logic [31:0] new_w, input logic [3:0] sel);
		logic [31:0] mask;
		mask = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
		return (old_w & ~mask) | (new_w & mask);
	endfunction

	function automatic logic [31:0] time_word(input cst_pkg::cst_time_s t);
		logic [31:0] w;
		w = 32'h0;
		w[`CST_HOUR_LSB +: 5] = t.hour;
		w[`CST_MIN_LSB +: 6] = t.minute;
		w[`CST_SEC_LSB +: 6] = t.second;
		return w;
	endfunction

	function automatic cst_pkg::cst_time_s word_time(input logic [31:0] w);
		cst_pkg::cst_time_s t;
		t.hour = w[`CST_HOUR_LSB +: 5];
		t.minute = w[`CST_MIN_LSB +: 6];
		t.second = w[`CST_SEC_LSB +: 6];
		return t;
	endfunction

	function automatic logic day_enabled(input cst_pkg::cst_mode_t mode, input logic [2:0] wday);
		logic ok;
		ok = 1'b0;
		case (mode)
			`CST_MODE_DAILY: ok = 1'b1; // R5
			`CST_MODE_WORKDAYS_ONLY: ok = (wday <= `CST_DAY_FRIDAY); // R7
			`CST_MODE_MONDAY_TO_SATURDAY: ok = (wday <= `CST_DAY_SATURDAY); // R8
			`CST_MODE_WEEKEND_ONLY: ok = (wday == `CST_DAY_SATURDAY) || (wday == `CST_DAY_SUNDAY); // R9
			default:
			begin
				// single weekday modes; codes above weekend_only are unused and never switch
				if (mode >= `CST_MODE_MONDAY && mode <= `CST_MODE_SUNDAY)
				begin
					ok = (wday == 3'(mode - `CST_MODE_MONDAY)); // R6
				end
			end
		endcase
		return ok;
	endfunction

	// power fail comes from a pin, so it passes two flip-flops first
	logic pf_meta;
	logic pf_sync;
	logic pf_last;
	wire pf_rise = pf_sync & ~pf_last;

	cst_seq_e seq;
	logic [1:0] seq_idx;
	wire seq_last = (seq_idx == 2'(CHANNELS - 1));

	cst_pkg::cst_time_s on_time [CHANNELS];
	cst_pkg::cst_time_s off_time [CHANNELS];
	cst_pkg::cst_mode_t mode [CHANNELS];
	logic [CHANNELS-1:0] active;
	logic [CHANNELS-1:0] on_hit_q;
	logic [CHANNELS-1:0] off_hit_q;

	cst_pkg::cst_saved_s rd_saved;
	cst_pkg::cst_saved_s wr_saved;

	// bus decode
	wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire bus_wr = bus_req & wb_we_i;
	wire in_chan_space = (wb_adr_i[AW-1:6] == '0);
	wire [1:0] sel_chan = wb_adr_i[5:4];
	wire [1:0] sel_reg = wb_adr_i[3:2];
	wire is_summary = (wb_adr_i == AW'(`CST_REG_SUMMARY));

	wire load_stb = (seq == SEQ_LOAD) && (rd_saved.mark == `CST_SAVED_MARK);
	wire save_we = (seq == SEQ_SAVE);

	assign wr_saved.mark = `CST_SAVED_MARK;
	assign wr_saved.active = active[seq_idx];

	logic [31:0] chan_word [CHANNELS];
	logic [CHANNELS-1:0] running;

	genvar gi;
	generate
		for (gi = 0; gi < CHANNELS; gi++)
		begin : g_chan
			wire sel_me = bus_wr & in_chan_space & (sel_chan == 2'(gi));
			wire wr_on = sel_me & (sel_reg == `CST_REG_ON);
			wire wr_off = sel_me & (sel_reg == `CST_REG_OFF);
			wire wr_mode = sel_me & (sel_reg == `CST_REG_MODE);
			wire wr_state = sel_me & (sel_reg == `CST_REG_STATE) & wb_sel_i[0];
			wire day_ok = day_enabled(mode[gi], cal_i.wday);
			wire on_hit = day_ok & (cal_i.tod == on_time[gi]); // R16
			wire off_hit = day_ok & (cal_i.tod == off_time[gi]); // R16
			// the calendar stays on one second for many clocks, so act on the first only
			wire on_evt = on_hit & ~on_hit_q[gi];
			wire off_evt = off_hit & ~off_hit_q[gi];
			wire restore_me = load_stb & (seq_idx == 2'(gi));
			wire [31:0] on_w = merge_bytes(time_word(on_time[gi]), wb_dat_i, wb_sel_i);
			wire [31:0] off_w = merge_bytes(time_word(off_time[gi]), wb_dat_i, wb_sel_i);

			assign running[gi] = (mode[gi] != `CST_MODE_DISABLED); // R3

			always_comb
			begin
				case (sel_reg)
					`CST_REG_ON: chan_word[gi] = time_word(on_time[gi]);
					`CST_REG_OFF: chan_word[gi] = time_word(off_time[gi]);
					`CST_REG_MODE: chan_word[gi] = {28'h0, mode[gi]};
					default: chan_word[gi] = {30'h0, running[gi] ? {1'b1, active[gi]} :
						`CST_STATE_UNUSED}; // R15
				endcase
			end

			always_ff @(posedge clk_i)
			begin
				if (rst_i)
				begin
					on_time[gi] <= `CST_TIME_RST;
					off_time[gi] <= `CST_TIME_RST;
					mode[gi] <= `CST_MODE_RST;
					on_hit_q[gi] <= 1'b0;
					off_hit_q[gi] <= 1'b0;
				end
				else
				begin
					on_hit_q[gi] <= on_hit;
					off_hit_q[gi] <= off_hit;
					if (wr_on)
					begin
						on_time[gi] <= word_time(on_w); // R2
					end
					if (wr_off)
					begin
						off_time[gi] <= word_time(off_w); // R2
					end
					if (wr_mode && wb_sel_i[0])
					begin
						mode[gi] <= cst_pkg::cst_mode_t'(wb_dat_i[3:0]); // R3
					end
				end
			end

			// the stored state is kept while disabled so a restored value survives until use
			always_ff @(posedge clk_i)
			begin
				if (rst_i)
				begin
					active[gi] <= 1'b0;
				end
				else if (restore_me)
				begin
					active[gi] <= rd_saved.active; // R13
				end
				else if (wr_state && running[gi])
				begin
					active[gi] <= wb_dat_i[0]; // R10 R11 R12
				end
				else if (running[gi] && off_evt)
				begin
					active[gi] <= 1'b0; // R12 R16
				end
				else if (running[gi] && on_evt)
				begin
					active[gi] <= 1'b1; // R12 R16
				end
			end
		end
	endgenerate

	cst_nv_store #(
		.WIDTH(2),
		.DEPTH(CHANNELS),
		.AW(2)
	) u_store (
		.clk_i(clk_i),
		.we_i(save_we),
		.waddr_i(seq_idx),
		.wdata_i(wr_saved),
		.raddr_i(seq_idx),
		.rdata_o(rd_saved)
	);

	// restore all channels after reset, save all on a power fail edge
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			seq <= SEQ_FETCH;
			seq_idx <= 2'h0;
		end
		else
		begin
			case (seq)
				SEQ_FETCH: seq <= SEQ_LOAD; // R13
				SEQ_LOAD:
				begin
					seq_idx <= seq_last ? 2'h0 : seq_idx + 2'h1;
					seq <= seq_last ? SEQ_RUN : SEQ_FETCH; // R13
				end
				SEQ_RUN:
				begin
					if (pf_rise)
					begin
						seq <= SEQ_SAVE; // R13
					end
				end
				SEQ_SAVE:
				begin
					seq_idx <= seq_last ? 2'h0 : seq_idx + 2'h1;
					if (seq_last)
					begin
						seq <= SEQ_RUN;
					end
				end
				default: seq <= SEQ_RUN;
			endcase
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			pf_meta <= 1'b0;
			pf_sync <= 1'b0;
			pf_last <= 1'b0;
		end
		else
		begin
			pf_meta <= power_fail_i;
			pf_sync <= pf_meta;
			pf_last <= pf_sync;
		end
	end

	wire [31:0] summary_word = {26'h0, (seq == SEQ_SAVE), (seq != SEQ_RUN && seq != SEQ_SAVE),
		4'(active & running)};
	wire [31:0] rd_word = in_chan_space ? chan_word[sel_chan] :
		(is_summary ? summary_word : 32'h0);

	// one wait state: ack follows the request by one edge; unmapped reads give zero
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0;
			sched_out_o <= '0;
			restore_busy_o <= 1'b1;
		end
		else
		begin
			wb_ack_o <= bus_req;
			wb_dat_o <= (bus_req && !wb_we_i) ? rd_word : 32'h0;
			sched_out_o <= active & running; // R4 R14
			restore_busy_o <= (seq == SEQ_FETCH) || (seq == SEQ_LOAD);
		end
	end
endmodule

//--- verification/cst_matrix_model.sv
// stand-in for the logic and output matrix fed by the timers
`timescale 1ns/1ps
module cst_matrix_model (
	input wire logic clk_i,
	input wire logic [3:0] sched_i,
	output logic [3:0] level_o
);
	// registered like any matrix input, so it lags the timers by a cycle
	always @(posedge clk_i)
		level_o <= sched_i;
endmodule

//--- verification/cst_sched_timers_props.sv
// checker of the schedule timer ports
`timescale 1ns/1ps
module cst_props #(
	parameter int CHANNELS = 4
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [31:0] wb_dat_o,
	input wire logic wb_ack_o,
	input wire logic [CHANNELS-1:0] sched_out_o,
	input wire logic restore_busy_o
);
	wire take = wb_cyc_i && wb_stb_i && !wb_ack_o;
	default clocking @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	AST_ACK_NEXT: assert property (take |=> wb_ack_o) else $error("no ack");
	AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o) else $error("long ack");
	AST_ACK_CAUSE: assert property (!take |=> !wb_ack_o) else $error("stray ack");
	AST_DAT_IDLE: assert property (!wb_ack_o |-> !wb_dat_o) else $error("idle data");
	AST_DAT_WR: assert property (wb_ack_o && wb_we_i |-> !wb_dat_o) else $error("wr data");
	AST_RST_OUT: assert property ($fell(rst_i) |-> !sched_out_o && restore_busy_o)
		else $error("reset state");
	// restore walks all four channels, so busy cannot drop early
	AST_RESTORE: assert property ($fell(rst_i) |->
		restore_busy_o [*7] ##[1:4] !restore_busy_o) else $error("restore time");
	AST_BUSY_ONCE: assert property ($fell(restore_busy_o) |=> !restore_busy_o [*8])
		else $error("restore again");
	cover property (take && wb_we_i);
	cover property ($rose(sched_out_o[0]));
	cover property ($fell(restore_busy_o));
endmodule
bind cst_sched_timers cst_props #(.CHANNELS(CHANNELS)) u_props (.clk_i, .rst_i, .wb_cyc_i,
	.wb_stb_i, .wb_we_i, .wb_dat_o, .wb_ack_o, .sched_out_o, .restore_busy_o);

//--- verification/cst_sched_timers_tb_top.sv
// bench for the schedule timers
`timescale 1ns/1ps
module cst_sched_timers_tb_top;
	logic clk_i = 1'h0, rst_i = 1'h1, cyc = 1'h0, we = 1'h0, pf = 1'h0, ack, busy;
	logic [7:0] adr = 8'h0;
	logic [31:0] dat = 32'h0, rdd;
	logic [3:0] so, lvl;
	cst_pkg::cst_cal_s cal = '0;
	int miscompares = 0, checks_done = 0;
	logic [31:0] q[$];
	always #12.5 clk_i = ~clk_i;
	cst_sched_timers DUT (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(rdd), .wb_ack_o(ack),
		.cal_i(cal), .power_fail_i(pf), .sched_out_o(so), .restore_busy_o(busy));
	cst_matrix_model MDL (.clk_i, .sched_i(so), .level_o(lvl));
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checks_done++;
		if (s !== e)
		begin
			miscompares++;
			$display("MISMATCH %0t saw %h want %h", $time, s, e);
		end
	endtask
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic hang(input int n);
		if (n >= 40)
		begin
			miscompares++;
			end_of_test();
		end
	endtask
	task automatic tick();
		repeat (4) @(posedge clk_i);
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n = 0;
		@(posedge clk_i);
		cyc <= 1'h1;
		we <= w;
		adr <= a;
		dat <= d;
		do
			@(posedge clk_i);
		while (ack !== 1'h1 && ++n < 40);
		hang(n);
		cyc <= 1'h0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		q.push_back(e);
		bus(1'h0, a, 32'h0);
	endtask
	task automatic reset();
		int n = 0;
		rst_i <= 1'h1;
		repeat (4) @(posedge clk_i);
		rst_i <= 1'h0;
		do
			@(posedge clk_i);
		while (busy !== 1'h0 && ++n < 40);
		hang(n);
	endtask
	function automatic logic en(input int m, input int d);
		return m == 1 || m == d + 2 || (m == 9 && d < 5)
			|| (m == 10 && d < 6) || (m == 11 && d > 4);
	endfunction
	function automatic logic [31:0] rv(input logic [16:0] t);
		return {11'h0, t[16:12], 2'h0, t[11:6], 2'h0, t[5:0]};
	endfunction
	always @(posedge clk_i)
		if (ack && !we)
			chk(rdd, q.pop_front());
	initial
	begin
		logic [16:0] t, u;
		int c;
		c = $urandom(51);
		reset();
		rd(8'h40, 32'h0);
		rd(8'h44, 32'h0);
		for (int m = 0; m < 12; m++)
		begin
			c = m % 4;
			t = {5'($urandom_range(11)), 6'($urandom_range(59)), 6'($urandom_range(59))};
			u = t + 17'h0c000;
			bus(1'h1, 8'(c * 16), rv(t));
			bus(1'h1, 8'(c * 16 + 4), rv(u));
			bus(1'h1, 8'(c * 16 + 8), 32'(m));
			rd(8'(c * 16 + 4), rv(u));
			for (int d = 0; d < 7; d++)
			begin
				cal <= {t, 3'(d)};
				tick();
				chk(32'({so[c], lvl[c]}), 32'({2{en(m, d)}}));
				rd(8'(c * 16 + 12), m ? 32'(en(m, d)) + 32'h2 : 32'h0);
				cal <= {u, 3'(d)};
				tick();
				chk(32'(so[c]), 32'h0);
			end
		end
		$display("modes done");
		bus(1'h1, 8'h10, 32'h10000);
		bus(1'h1, 8'h14, 32'h20000);
		bus(1'h1, 8'h18, 32'h1);
		bus(1'h1, 8'h1c, 32'h3);
		tick();
		chk(32'(so[1]), 32'h1);
		cal <= {17'h02000, 3'h6};
		tick();
		chk(32'(so[1]), 32'h0);
		bus(1'h1, 8'h1c, 32'h3);
		bus(1'h1, 8'h28, 32'h0);
		bus(1'h1, 8'h2c, 32'h3);
		rd(8'h2c, 32'h0);
		rd(8'h1c, 32'h3);
		$display("forcing done");
		bus(1'h1, 8'h0c, 32'h3);
		bus(1'h1, 8'h3c, 32'h2);
		pf <= 1'h1;
		repeat (12) @(posedge clk_i);
		pf <= 1'h0;
		reset();
		rd(8'h40, 32'h0);
		for (int i = 0; i < 4; i++)
			bus(1'h1, 8'(i * 16 + 8), 32'h1);
		rd(8'h40, 32'h3);
		// let the watcher take the last read before the run ends
		tick();
		chk(32'(q.size()), 32'h0);
		$display("retention done");
		end_of_test();
	end
endmodule
